// File: verilog/pbu_pkg.sv
/*
  pbu_pkg: register indices, field positions, reset values and pin-function
  encodings for the port-B uart pin routing block.
  assumes: apb with 32-bit data, one register per aligned word, byte address
  equal to four times the register index.
*/
package pbu_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] PBU_IDX_OUTPUT_DATA = 16'hF258;
  localparam logic [15:0] PBU_IDX_DIRECTION = 16'hF259;
  localparam logic [15:0] PBU_IDX_DRIVE_LOW = 16'hF25A;
  localparam logic [15:0] PBU_IDX_DRIVE_HIGH = 16'hF25B;
  localparam logic [15:0] PBU_IDX_FUNC_LOW = 16'hF25C;
  localparam logic [15:0] PBU_IDX_FUNC_HIGH = 16'hF25D;
  localparam logic [15:0] PBU_IDX_UART0_MODE0 = 16'hF25E;
  localparam logic [15:0] PBU_IDX_PIN_LEVEL = 16'hF25F;

  // bus geometry
  localparam int PBU_ADDR_W = 20;
  localparam int PBU_DATA_W = 32;
  localparam int PBU_PORT_W = 8;

  // reset values
  localparam logic [7:0] PBU_RST_OUTPUT_DATA = 8'h00;
  localparam logic [7:0] PBU_RST_DIRECTION = 8'h00;
  localparam logic [7:0] PBU_RST_DRIVE = 8'h00;
  localparam logic [7:0] PBU_RST_FUNC = 8'h00;
  localparam logic [7:0] PBU_RST_UART0_MODE0 = 8'h00;

  // field positions
  localparam int PBU_RX0_SEL_BIT = 4;

  // pin numbers used by the uart functions
  localparam int PBU_PIN_RX0_DEFAULT = 0;
  localparam int PBU_PIN_TX_A = 1;
  localparam int PBU_PIN_RX1 = 2;
  localparam int PBU_PIN_TX1_TERT = 3;
  localparam int PBU_PIN_TX0_TERT = 4;
  localparam int PBU_PIN_RX0_ALT = 5;

  // function mode {upper, lower}
  localparam logic [1:0] PBU_FN_PRIMARY = 2'h0;
  localparam logic [1:0] PBU_FN_SECONDARY = 2'h1;
  localparam logic [1:0] PBU_FN_TERTIARY = 2'h2;
  localparam logic [1:0] PBU_FN_FOURTH = 2'h3;

  // drive control {upper, lower} while direction is output
  localparam logic [1:0] PBU_DRV_HIZ = 2'h0;
  localparam logic [1:0] PBU_DRV_PCH_OPEN = 2'h1;
  localparam logic [1:0] PBU_DRV_NCH_OPEN = 2'h2;
  localparam logic [1:0] PBU_DRV_CMOS = 2'h3;

  // bus answer phases
  typedef enum logic [0:0] {
    PBU_BUS_IDLE = 1'b0,
    PBU_BUS_ANSWER = 1'b1
  } pbu_bus_e;

endpackage : pbu_pkg

// File: verilog/pbu_pin_cell.sv
/*
  pbu_pin_cell: one port pin. registers the output value and output enable,
  and brings the pin level into the clock domain through three flip-flops.
  assumes: drive inputs come from logic on sys_clk; pin_in is asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none

module pbu_pin_cell (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // drive request from the routing logic
  input wire logic drive_en,
  input wire logic drive_val,
  // pad side
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // filtered level
  output logic pin_level
);

  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic next_sync_a;
  logic next_sync_b;
  logic next_sync_c;
  logic next_pin_out;
  logic next_pin_oe;
  logic next_pin_level;

  always_comb begin
    next_sync_a = pin_in;
    next_sync_b = sync_a;
    next_sync_c = sync_b;
    next_pin_out = drive_val;
    next_pin_oe = drive_en;
    // a change counts only once the later two stages agree
    next_pin_level = (sync_b == sync_c) ? sync_c : pin_level;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      pin_level <= 1'b0;
    end else if (clk_en) begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      sync_c <= next_sync_c;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pin_level <= next_pin_level;
    end
  end

endmodule : pbu_pin_cell

`default_nettype wire

// File: verilog/pbu_pin_routing.sv
/*
  pbu_pin_routing: port-B register file on apb and the routing of the two
  uart channels onto the eight port pins.
  assumes: uart transmit levels come from logic on sys_clk; pads resolve the
  wire from pin_out and pin_oe; the apb master holds a request until pready.
*/
// Added by the designer: the APB slave port.
// Function
// - pin 4 in tertiary mode carries the channel 0 transmit output.
// - pin 3 in tertiary mode carries the channel 1 transmit output.
// - pin 1 in fourth mode carries the channel 1 transmit output.
// - pin 5 in primary mode can be used as the channel 0 receive input.
// - pin 2 in primary mode serves as the channel 1 receive input.
// - an output pin with both drive bits set is driven push-pull.
// - a pin with its direction bit set is an input and is not driven.
// - output-data bits of uart pins have no effect on uart traffic.
// - bit 4 of the channel 0 mode register picks pin 0 (reset) or pin 5 for receive.
// - with that bit at 0 receive comes from pin 0 whatever pin 5's setup.
`timescale 1ns/100ps
`default_nettype none

module pbu_pin_routing (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pbu_pkg::PBU_ADDR_W-1:0] paddr,
  input wire logic [pbu_pkg::PBU_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [pbu_pkg::PBU_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // uart engines
  input wire logic uart0_transmit_out,
  input wire logic uart1_transmit_out,
  output logic uart0_receive_in,
  output logic uart1_receive_in,
  // port pins
  input wire logic [pbu_pkg::PBU_PORT_W-1:0] port_pin_in,
  output logic [pbu_pkg::PBU_PORT_W-1:0] port_pin_out,
  output logic [pbu_pkg::PBU_PORT_W-1:0] port_pin_oe
);
  import pbu_pkg::*;

  // registers
  logic [7:0] port_output_data;
  logic [7:0] port_direction;
  logic [7:0] port_drive_control_low;
  logic [7:0] port_drive_control_high;
  logic [7:0] port_function_select_low;
  logic [7:0] port_function_select_high;
  logic [7:0] uart0_mode_register0;
  logic [7:0] next_port_output_data;
  logic [7:0] next_port_direction;
  logic [7:0] next_port_drive_control_low;
  logic [7:0] next_port_drive_control_high;
  logic [7:0] next_port_function_select_low;
  logic [7:0] next_port_function_select_high;
  logic [7:0] next_uart0_mode_register0;

  // bus state
  pbu_bus_e bus_state;
  pbu_bus_e next_bus_state;
  logic [PBU_DATA_W-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // address decode
  logic [PBU_ADDR_W-3:0] reg_index;
  logic addr_aligned;
  logic hit_output_data;
  logic hit_direction;
  logic hit_drive_low;
  logic hit_drive_high;
  logic hit_func_low;
  logic hit_func_high;
  logic hit_uart0_mode0;
  logic hit_pin_level;
  logic hit_any;
  logic write_fire;
  logic [7:0] read_byte;

  // pin routing
  logic [PBU_PORT_W-1:0] pin_level;
  logic [PBU_PORT_W-1:0] drive_en;
  logic [PBU_PORT_W-1:0] drive_val;
  logic [PBU_PORT_W-1:0] uart_tx_sel;
  logic [PBU_PORT_W-1:0] uart_tx_val;
  logic next_uart0_receive_in;
  logic next_uart1_receive_in;

  // decode only word-aligned addresses; byte address is index times four
  always_comb begin
    reg_index = paddr[PBU_ADDR_W-1:2];
    addr_aligned = (paddr[1:0] == 2'h0);
    hit_output_data = addr_aligned && (reg_index == 18'(PBU_IDX_OUTPUT_DATA));
    hit_direction = addr_aligned && (reg_index == 18'(PBU_IDX_DIRECTION));
    hit_drive_low = addr_aligned && (reg_index == 18'(PBU_IDX_DRIVE_LOW));
    hit_drive_high = addr_aligned && (reg_index == 18'(PBU_IDX_DRIVE_HIGH));
    hit_func_low = addr_aligned && (reg_index == 18'(PBU_IDX_FUNC_LOW));
    hit_func_high = addr_aligned && (reg_index == 18'(PBU_IDX_FUNC_HIGH));
    hit_uart0_mode0 = addr_aligned && (reg_index == 18'(PBU_IDX_UART0_MODE0));
    hit_pin_level = addr_aligned && (reg_index == 18'(PBU_IDX_PIN_LEVEL));
    hit_any = hit_output_data || hit_direction || hit_drive_low || hit_drive_high
      || hit_func_low || hit_func_high || hit_uart0_mode0 || hit_pin_level;
  end

  // read mux; the level register shows the filtered pin levels
  always_comb begin
    read_byte = 8'h00;
    if (hit_output_data) begin
      read_byte = port_output_data;
    end else if (hit_direction) begin
      read_byte = port_direction;
    end else if (hit_drive_low) begin
      read_byte = port_drive_control_low;
    end else if (hit_drive_high) begin
      read_byte = port_drive_control_high;
    end else if (hit_func_low) begin
      read_byte = port_function_select_low;
    end else if (hit_func_high) begin
      read_byte = port_function_select_high;
    end else if (hit_uart0_mode0) begin
      read_byte = uart0_mode_register0;
    end else if (hit_pin_level) begin
      read_byte = pin_level;
    end
  end

  // no wait state: pready rises in the first access cycle, from a flop
  always_comb begin
    next_bus_state = bus_state;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    case (bus_state)
      PBU_BUS_IDLE: begin
        if (psel && !penable) begin
          next_bus_state = PBU_BUS_ANSWER;
          next_pready = 1'b1;
          next_pslverr = !hit_any;
          next_prdata = (!pwrite && hit_any) ? {24'h000000, read_byte} : 32'h00000000;
        end
      end
      PBU_BUS_ANSWER: begin
        next_bus_state = PBU_BUS_IDLE;
      end
      default: begin
        next_bus_state = PBU_BUS_IDLE;
      end
    endcase
  end

  // write takes effect at the edge that sees pready high
  always_comb begin
    write_fire = psel && penable && pready && pwrite && pstrb[0];
    next_port_output_data = port_output_data;
    next_port_direction = port_direction;
    next_port_drive_control_low = port_drive_control_low;
    next_port_drive_control_high = port_drive_control_high;
    next_port_function_select_low = port_function_select_low;
    next_port_function_select_high = port_function_select_high;
    next_uart0_mode_register0 = uart0_mode_register0;
    if (write_fire) begin
      if (hit_output_data) begin
        next_port_output_data = pwdata[7:0];
      end
      if (hit_direction) begin
        next_port_direction = pwdata[7:0];
      end
      if (hit_drive_low) begin
        next_port_drive_control_low = pwdata[7:0];
      end
      if (hit_drive_high) begin
        next_port_drive_control_high = pwdata[7:0];
      end
      if (hit_func_low) begin
        next_port_function_select_low = pwdata[7:0];
      end
      if (hit_func_high) begin
        next_port_function_select_high = pwdata[7:0];
      end
      if (hit_uart0_mode0) begin
        next_uart0_mode_register0 = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_state <= PBU_BUS_IDLE;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      port_output_data <= PBU_RST_OUTPUT_DATA;
      port_direction <= PBU_RST_DIRECTION;
      port_drive_control_low <= PBU_RST_DRIVE;
      port_drive_control_high <= PBU_RST_DRIVE;
      port_function_select_low <= PBU_RST_FUNC;
      port_function_select_high <= PBU_RST_FUNC;
      uart0_mode_register0 <= PBU_RST_UART0_MODE0;
    end else if (clk_en) begin
      bus_state <= next_bus_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      port_output_data <= next_port_output_data;
      port_direction <= next_port_direction;
      port_drive_control_low <= next_port_drive_control_low;
      port_drive_control_high <= next_port_drive_control_high;
      port_function_select_low <= next_port_function_select_low;
      port_function_select_high <= next_port_function_select_high;
      uart0_mode_register0 <= next_uart0_mode_register0;
    end
  end

  // transmit routing per pin from its two function bits
  always_comb begin
    uart_tx_sel = '0;
    uart_tx_val = '0;
    for (int i = 0; i < PBU_PORT_W; i++) begin
      case ({port_function_select_high[i], port_function_select_low[i]})
        PBU_FN_TERTIARY: begin
          if (i == PBU_PIN_TX0_TERT || i == PBU_PIN_TX_A) begin
            uart_tx_sel[i] = 1'b1;
            uart_tx_val[i] = uart0_transmit_out;
          end else if (i == PBU_PIN_TX1_TERT) begin
            uart_tx_sel[i] = 1'b1;
            uart_tx_val[i] = uart1_transmit_out;
          end
        end
        PBU_FN_FOURTH: begin
          if (i == PBU_PIN_TX_A || i == PBU_PIN_TX0_TERT) begin
            uart_tx_sel[i] = 1'b1;
            uart_tx_val[i] = uart1_transmit_out;
          end
        end
        default: begin
          // primary and secondary: plain port control
          uart_tx_sel[i] = 1'b0;
        end
      endcase
    end
  end

  // driver modes; open-drain modes drive only one level
  always_comb begin
    drive_en = '0;
    drive_val = '0;
    for (int i = 0; i < PBU_PORT_W; i++) begin
      // uart pins ignore the stored output bit
      drive_val[i] = uart_tx_sel[i] ? uart_tx_val[i] : port_output_data[i];
      if (port_direction[i]) begin
        drive_en[i] = 1'b0;
      end else begin
        case ({port_drive_control_high[i], port_drive_control_low[i]})
          PBU_DRV_CMOS: drive_en[i] = 1'b1;
          PBU_DRV_NCH_OPEN: drive_en[i] = !drive_val[i];
          PBU_DRV_PCH_OPEN: drive_en[i] = drive_val[i];
          PBU_DRV_HIZ: drive_en[i] = 1'b0;
          default: drive_en[i] = 1'b0;
        endcase
      end
    end
  end

  for (genvar g = 0; g < PBU_PORT_W; g++) begin : g_pin
    pbu_pin_cell u_cell (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .drive_en(drive_en[g]),
      .drive_val(drive_val[g]),
      .pin_in(port_pin_in[g]),
      .pin_out(port_pin_out[g]),
      .pin_oe(port_pin_oe[g]),
      .pin_level(pin_level[g])
    );
  end

  // receive taken from the filtered level whatever the pin mode, so a
  // misconfigured pin still shows its level rather than a stuck value
  always_comb begin
    if (uart0_mode_register0[PBU_RX0_SEL_BIT]) begin
      next_uart0_receive_in = pin_level[PBU_PIN_RX0_ALT];
    end else begin
      next_uart0_receive_in = pin_level[PBU_PIN_RX0_DEFAULT];
    end
    next_uart1_receive_in = pin_level[PBU_PIN_RX1];
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      uart0_receive_in <= 1'b0;
      uart1_receive_in <= 1'b0;
    end else if (clk_en) begin
      uart0_receive_in <= next_uart0_receive_in;
      uart1_receive_in <= next_uart1_receive_in;
    end
  end

endmodule : pbu_pin_routing

`default_nettype wire

// File: tb/pbu_pin_routing_sva.sv
/*
  pbu_pin_routing_sva: routing, drive and receive checks at the block ports.
  assumes: one clock; a register write lands where pready is sampled high.
*/
`timescale 1ns/100ps
`default_nettype none

module pbu_pin_routing_sva (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pbu_pkg::PBU_ADDR_W-1:0] paddr,
  input wire logic [pbu_pkg::PBU_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  // uart and pads
  input wire logic uart0_transmit_out,
  input wire logic uart1_transmit_out,
  input wire logic uart0_receive_in,
  input wire logic uart1_receive_in,
  input wire logic [pbu_pkg::PBU_PORT_W-1:0] port_pin_in,
  input wire logic [pbu_pkg::PBU_PORT_W-1:0] port_pin_out,
  input wire logic [pbu_pkg::PBU_PORT_W-1:0] port_pin_oe
);
  import pbu_pkg::*;
  // shadow of the writable registers, rebuilt from observed writes
  logic [7:0] sh [0:7];
  logic [17:0] idx;
  logic wr_hit;
  assign idx = paddr[19:2];
  assign wr_hit = clk_en && psel && penable && pready && pwrite && !pslverr && pstrb[0]
    && paddr[1:0] == 2'h0 && idx >= PBU_IDX_OUTPUT_DATA && idx <= PBU_IDX_UART0_MODE0;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++)
        sh[i] <= 8'h00;
    end else if (wr_hit) begin
      sh[idx[2:0]] <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  property p_tx0_pin4;
    $past(clk_en && !sys_rst && sh[5][4] && !sh[4][4]) |->
      port_pin_out[4] == $past(uart0_transmit_out);
  endproperty
  a_tx0_pin4: assert property (p_tx0_pin4) else $error("pin 4 lost uart0 tx");
  property p_tx1_pin3;
    $past(clk_en && !sys_rst && sh[5][3] && !sh[4][3]) |->
      port_pin_out[3] == $past(uart1_transmit_out);
  endproperty
  a_tx1_pin3: assert property (p_tx1_pin3) else $error("pin 3 lost uart1 tx");
  property p_tx1_pin1;
    $past(clk_en && !sys_rst && sh[5][1] && sh[4][1]) |->
      port_pin_out[1] == $past(uart1_transmit_out);
  endproperty
  a_tx1_pin1: assert property (p_tx1_pin1) else $error("pin 1 lost uart1 tx");
  property p_cmos;
    $past(clk_en && !sys_rst && |(~sh[1] & sh[3] & sh[2])) |->
      (port_pin_oe & $past(~sh[1] & sh[3] & sh[2])) == $past(~sh[1] & sh[3] & sh[2]);
  endproperty
  a_cmos: assert property (p_cmos) else $error("push-pull pin not driven");
  property p_input;
    $past(clk_en && !sys_rst && |sh[1]) |-> (port_pin_oe & $past(sh[1])) == 8'h00;
  endproperty
  a_input: assert property (p_input) else $error("input pin driven");
  property p_plain;
    $past(clk_en && !sys_rst) |-> ((port_pin_out ^ $past(sh[0])) & ~$past(sh[5])) == 8'h00;
  endproperty
  a_plain: assert property (p_plain) else $error("plain pin not port data");
  property p_rx0_pin5;
    (clk_en && sh[6][4] && $stable(port_pin_in[5]))[*6] |-> uart0_receive_in == port_pin_in[5];
  endproperty
  a_rx0_pin5: assert property (p_rx0_pin5) else $error("uart0 rx not pin 5");
  property p_rx0_pin0;
    (clk_en && !sh[6][4] && $stable(port_pin_in[0]))[*6] |-> uart0_receive_in == port_pin_in[0];
  endproperty
  a_rx0_pin0: assert property (p_rx0_pin0) else $error("uart0 rx not pin 0");
  property p_rx1_pin2;
    (clk_en && $stable(port_pin_in[2]))[*6] |-> uart1_receive_in == port_pin_in[2];
  endproperty
  a_rx1_pin2: assert property (p_rx1_pin2) else $error("uart1 rx not pin 2");
endmodule : pbu_pin_routing_sva

bind pbu_pin_routing pbu_pin_routing_sva u_pbu_pin_routing_sva (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .pslverr(pslverr), .uart0_transmit_out(uart0_transmit_out),
  .uart1_transmit_out(uart1_transmit_out), .uart0_receive_in(uart0_receive_in),
  .uart1_receive_in(uart1_receive_in), .port_pin_in(port_pin_in),
  .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe)
);

`default_nettype wire

// File: tb/pbu_serial_dev.sv
/*
  pbu_serial_dev: external serial device on the pads; drives receive pins.
  assumes: dev_tx changes just after a rising edge; no pulls on any pad.
*/
`timescale 1ns/100ps
`default_nettype none

module pbu_serial_dev (
  // clock
  input wire logic sys_clk,
  // device levels for pins 0, 2 and 5
  input wire logic [2:0] dev_tx,
  // pads
  input wire logic [7:0] port_pin_out,
  input wire logic [7:0] port_pin_oe,
  output logic [7:0] port_pin_in
);
  // no pull-ups: a floating pad toggles so a stale level never passes
  logic float_lvl = 1'b0;
  logic [7:0] ext_drv;
  always @(posedge sys_clk) begin
    float_lvl <= ~float_lvl;
  end
  always_comb begin
    ext_drv = {8{float_lvl}};
    ext_drv[0] = dev_tx[0];
    ext_drv[2] = dev_tx[1];
    ext_drv[5] = dev_tx[2];
    for (int i = 0; i < 8; i++)
      port_pin_in[i] = port_pin_oe[i] ? port_pin_out[i] : ext_drv[i];
  end
endmodule : pbu_serial_dev

`default_nettype wire

// File: tb/pbu_pin_routing_tb_top.sv
/*
  pbu_pin_routing_tb_top: self-checking bench for the uart pin routing.
  assumes: apb slave answers in bounded time; serial device model on pads.
*/
`timescale 1ns/100ps
`default_nettype none

module pbu_pin_routing_tb_top;
  import pbu_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [19:0] paddr = 20'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic uart0_transmit_out = 1'b0, uart1_transmit_out = 1'b0;
  logic uart0_receive_in, uart1_receive_in;
  logic [2:0] dev_tx = 3'h0;
  logic [7:0] port_pin_in, port_pin_out, port_pin_oe, lfsr = 8'h12, v, d, e;
  int n_mismatch = 0, checked = 0;

  pbu_pin_routing u_pbu_pin_routing (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .uart0_transmit_out(uart0_transmit_out), .uart1_transmit_out(uart1_transmit_out),
    .uart0_receive_in(uart0_receive_in), .uart1_receive_in(uart1_receive_in),
    .port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe));
  pbu_serial_dev u_pbu_serial_dev (.sys_clk(sys_clk), .dev_tx(dev_tx),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe), .port_pin_in(port_pin_in));

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  // pad levels for the routing set up below
  function automatic logic [7:0] exp_pins(input logic [7:0] dat, input logic t0, input logic t1,
    input logic alt);
    logic [7:0] r;
    r = dat;
    r[4] = t0;
    // second setup: pin 3 in fourth mode is plain port, pin 1 tertiary carries tx0
    r[3] = alt ? dat[3] : t1;
    r[1] = alt ? t0 : t1;
    return r;
  endfunction : exp_pins
  task automatic rnd(output logic [7:0] o);
    lfsr = lfsr_next(lfsr);
    o = lfsr;
  endtask : rnd
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // reset value, then random write and readback, of each stored register
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 16'(PBU_IDX_OUTPUT_DATA + i), 8'h00);
      check("reset value", rd, 32'h0);
      rnd(v);
      apb(1'b1, 16'(PBU_IDX_OUTPUT_DATA + i), v);
      apb(1'b0, 16'(PBU_IDX_OUTPUT_DATA + i), 8'h00);
      check("readback", rd, {24'h0, v});
    end
    apb(1'b0, 16'hF260, 8'h00);
    check("unmapped error", {31'h0, err}, 32'h1);
    // tx0 on pin 4, tx1 on pins 3 and 1, receive on 0, 2, 5, plain pins 6, 7
    apb(1'b1, PBU_IDX_FUNC_HIGH, 8'h1A);
    apb(1'b1, PBU_IDX_FUNC_LOW, 8'h02);
    rnd(v);
    apb(1'b1, PBU_IDX_DRIVE_HIGH, 8'hDA | (v & 8'h25));
    rnd(v);
    apb(1'b1, PBU_IDX_DRIVE_LOW, 8'hDA | (v & 8'h25));
    apb(1'b1, PBU_IDX_DIRECTION, 8'h25);
    for (int s = 0; s < 2; s++) begin
      rnd(v);
      apb(1'b1, PBU_IDX_UART0_MODE0, {v[7:5], s[0], v[3:0]});
      if (s == 1) apb(1'b1, PBU_IDX_FUNC_LOW, 8'h08);
      for (int k = 0; k < 16; k++) begin
        rnd(d);
        apb(1'b1, PBU_IDX_OUTPUT_DATA, d);
        rnd(v);
        uart0_transmit_out <= v[0];
        uart1_transmit_out <= v[1];
        dev_tx <= v[4:2];
        repeat (6) @(posedge sys_clk);
        e = exp_pins(d, v[0], v[1], s[0]);
        check("pad levels", {24'h0, port_pin_out}, {24'h0, e});
        check("pad enables", {24'h0, port_pin_oe}, 32'hDA);
        check("uart1 receive", {31'h0, uart1_receive_in}, {31'h0, v[3]});
        check("uart0 receive", {31'h0, uart0_receive_in}, {31'h0, s[0] ? v[4] : v[2]});
      end
    end
    // frozen clock enable: pads hold while the transmit levels move
    clk_en <= 1'b0;
    uart0_transmit_out <= ~v[0];
    uart1_transmit_out <= ~v[1];
    repeat (4) @(posedge sys_clk);
    check("frozen pads", {24'h0, port_pin_out}, {24'h0, e});
    clk_en <= 1'b1;
    repeat (6) @(posedge sys_clk);
    e = exp_pins(d, ~v[0], ~v[1], 1'b1);
    check("thawed pads", {24'h0, port_pin_out}, {24'h0, e});
    // level register: driven pins read their own drive, inputs the device
    e[0] = v[2];
    e[2] = v[3];
    e[5] = v[4];
    apb(1'b0, PBU_IDX_PIN_LEVEL, 8'h00);
    check("pin levels", rd, {24'h0, e});
    give_verdict();
  end
endmodule : pbu_pin_routing_tb_top

`default_nettype wire
